// ===== hdl/rcc_pkg.sv
package rcc_pkg;

  // Register word indices; byte address is four times the index
  localparam logic [1:0] REG_FLAGS_IDX   = 2'h0;
  localparam logic [1:0] REG_TRIGGER_IDX = 2'h1;
  localparam logic [1:0] REG_UNLOCK_IDX  = 2'h2;
  localparam logic [1:0] REG_STATUS_IDX  = 2'h3;

  // Cause flag positions
  localparam int FLAG_POWERON  = 0;
  localparam int FLAG_BROWNOUT = 1;
  localparam int FLAG_PIN      = 2;
  localparam int FLAG_WATCHDOG = 3;
  localparam int FLAG_SOFT     = 4;
  localparam int FLAG_DEBUG    = 5;
  localparam int SOFT_RESET_BIT = 0;

  localparam logic [5:0] FLAGS_RESET = 6'h01;
  localparam logic [7:0] IO_REGISTER_KEY_DEFAULT = 8'h5a;

  // Unlock window and timing
  localparam int UNLOCK_WINDOW_INSTR = 4;
  localparam int CLK_MHZ             = 200;
  localparam int INIT_BASE_NS        = 150;
  localparam int INIT_BASE_CYC       = (INIT_BASE_NS * CLK_MHZ + 999) / 1000;
  localparam int STARTUP_UNIT_CYC    = 64;
  localparam int SCAN_CYC            = 256;

  typedef struct packed {
    logic poweron;
    logic brownout;
    logic pin_low;
    logic watchdog;
    logic debug_port;
    logic hv_edge;
  } rcc_req_s;

  typedef struct packed {
    logic fuse_reload;
    logic debug_domain;
    logic volatile_domain;
    logic pc_clear;
  } rcc_dom_s;

  typedef enum logic [1:0] { RCC_IDLE, RCC_HOLD, RCC_INIT } rcc_state_e;

endpackage : rcc_pkg

// ===== hdl/rcc_unlock.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_unlock
  import rcc_pkg::*;
#(
  parameter int WINDOW = UNLOCK_WINDOW_INSTR
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Key write and instruction step
  input  wire logic       key_wr,
  input  wire logic [7:0] key_data,
  input  wire logic [7:0] key_value,
  input  wire logic       instr_step,
  input  wire logic       consume,
  // Unlock state
  output logic            open_win
);
  if (WINDOW < 1 || WINDOW > 15) begin : g_bad_window
    $error("bad window");
  end

  logic [3:0] left;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      left <= 4'h0;
    end else if (key_wr && key_data == key_value) begin
      left <= 4'(WINDOW);
    end else if (consume) begin
      left <= 4'h0;
    end else if (instr_step && left != 4'h0) begin
      left <= left - 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      open_win <= 1'b0;
    end else begin
      open_win <= (key_wr && key_data == key_value) ||
                  (!consume && left > 4'(instr_step ? 1 : 0));
    end
  end
endmodule : rcc_unlock
`default_nettype wire

// ===== hdl/rcc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         nrst,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  // Status
  output logic              done
);
  if (W < 4) begin : g_bad_width
    $error("timer too narrow");
  end

  logic [W-1:0] left;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      left <= '0;
    end else if (load) begin
      left <= count;
    end else if (left != '0) begin
      left <= left - W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      done <= 1'b0;
    end else begin
      done <= !load && (left == W'(1) || left == '0);
    end
  end
endmodule : rcc_timer
`default_nettype wire

// ===== hdl/rcc_ctrl.sv
// How it works
// - A high voltage applied to or removed from the pin causes a full reset.
// - All resets reload fuses and clear logic; only power-on and high voltage clear debug.
// - Pin reset lasts while pin low; supply resets last while voltage is low.
// - After release run initialization, lengthened by fuse start-up delay after supply resets.
// - A fuse-enabled memory checksum scan lengthens initialization further.
// - Reset requests are accepted in active mode and in every sleep mode.
// - Writes to the protected register without a valid unlock are ignored.
// - The software reset register is protected by the io register key.
// - Writing one clears a cause flag; writing zero leaves it.
// - Power-on reset clears all cause flags and sets the power-on flag.
// - Brown-out reset clears all flags except the power-on and brown-out flags.
// - Debug port or high-voltage reset sets the debug flag at bit five.
// - Soft, watchdog, pin, brown-out, power-on flags sit at bits four to zero.
// - Writing one to bit zero after unlock triggers a software reset.
// - The software reset bit always reads back zero.
// - The reset sequence starts right after the trigger bit is written.
// - After any reset the program counter is set to zero.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rcc_ctrl
  import rcc_pkg::*;
#(
  parameter int       TW        = 16,
  parameter logic [7:0] KEY     = IO_REGISTER_KEY_DEFAULT,
  parameter int       WINDOW    = UNLOCK_WINDOW_INSTR
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         nrst,
  // Wishbone slave
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [3:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o,
  // Reset requests
  input  wire rcc_req_s     req,
  input  wire logic         pin_reset_enable,
  // Processor instruction step, any power mode
  input  wire logic         instr_step,
  // Fuse fields
  input  wire logic [3:0]   startup_delay_field,
  input  wire logic [1:0]   checksum_source_field,
  // Domain resets
  output rcc_dom_s          dom
);
  // Longest initialization needs eleven bits
  if (TW < 11 || TW > 30) begin : g_bad_tw
    $error("bad timer width");
  end

  function automatic logic sel_reg(input logic [3:0] adr, input logic [1:0] idx);
    sel_reg = (adr[3:2] == idx) && (adr[1:0] == 2'h0);
  endfunction

  // Bus decode; writes land at the edge that sees ack high
  logic wb_req;
  logic wb_fin;
  logic wr_lo;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_fin = wb_cyc_i && wb_stb_i && wb_ack_o;
  assign wr_lo  = wb_fin && wb_we_i && wb_sel_i[0];

  // Requests
  logic pin_req;
  logic supply_req;
  logic debug_req;
  logic any_req;
  logic soft_req;
  logic hv_prev;
  logic hv_event;
  logic open_win;
  logic trig_wr;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hv_prev <= 1'b0;
    end else begin
      hv_prev <= req.hv_edge;
    end
  end
  assign hv_event = req.hv_edge != hv_prev;

  assign pin_req    = pin_reset_enable && req.pin_low;
  assign supply_req = req.poweron || req.brownout;
  assign debug_req  = req.debug_port || hv_event;
  assign any_req    = supply_req || pin_req || req.watchdog || debug_req || soft_req;

  assign trig_wr = wr_lo && sel_reg(wb_adr_i, REG_TRIGGER_IDX);
  rcc_unlock #(.WINDOW(WINDOW)) u_unlock (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .key_wr     (wr_lo && sel_reg(wb_adr_i, REG_UNLOCK_IDX)),
    .key_data   (wb_dat_i[7:0]),
    .key_value  (KEY),
    .instr_step (instr_step),
    .consume    (trig_wr),
    .open_win   (open_win)
  );
  assign soft_req = trig_wr && open_win && wb_dat_i[SOFT_RESET_BIT];

  // Sequencer
  rcc_state_e state;
  logic       supply_seen;
  logic       debug_seen;
  logic       tload;
  logic       tdone;
  logic [TW-1:0] init_len;

  always_comb begin
    init_len = TW'(INIT_BASE_CYC);
    if (supply_seen) begin
      init_len = init_len + TW'(startup_delay_field) * TW'(STARTUP_UNIT_CYC);
    end
    if (checksum_source_field != 2'h3) begin
      init_len = init_len + TW'(SCAN_CYC);
    end
  end

  assign tload = (state == RCC_HOLD) && !any_req;

  rcc_timer #(.W(TW)) u_timer (
    .core_clk (core_clk),
    .nrst     (nrst),
    .load     (tload),
    .count    (init_len),
    .done     (tdone)
  );

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= RCC_HOLD;
    end else begin
      unique case (state)
        RCC_IDLE: if (any_req) state <= RCC_HOLD;
        RCC_HOLD: if (!any_req) state <= RCC_INIT;
        RCC_INIT: begin
          if (any_req) state <= RCC_HOLD;
          else if (tdone) state <= RCC_IDLE;
        end
      endcase
    end
  end

  // Which domains the current reset reaches
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      supply_seen <= 1'b1;
      debug_seen  <= 1'b1;
    end else if (state == RCC_IDLE && !any_req) begin
      supply_seen <= 1'b0;
      debug_seen  <= 1'b0;
    end else begin
      if (supply_req) supply_seen <= 1'b1;
      if (req.poweron || hv_event) debug_seen <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dom <= '{fuse_reload: 1'b1, debug_domain: 1'b1, volatile_domain: 1'b1, pc_clear: 1'b1};
    end else begin
      dom.fuse_reload     <= any_req || state == RCC_HOLD;
      dom.volatile_domain <= any_req || state != RCC_IDLE;
      dom.pc_clear        <= any_req || state != RCC_IDLE;
      dom.debug_domain    <= (req.poweron || hv_event) ||
                             (debug_seen && state != RCC_IDLE);
    end
  end

  // Cause flags
  logic [5:0] flags;
  logic [5:0] set_v;
  logic [5:0] clr_v;
  assign set_v = {debug_req, soft_req, req.watchdog, pin_req, req.brownout, req.poweron};
  assign clr_v = (wr_lo && sel_reg(wb_adr_i, REG_FLAGS_IDX)) ? wb_dat_i[5:0] : 6'h00;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flags <= FLAGS_RESET;
    end else if (req.poweron) begin
      flags <= 6'h01;
    end else if (req.brownout) begin
      flags <= (flags & 6'h01) | 6'h02;
    end else begin
      flags <= (flags & ~clr_v) | set_v;
    end
  end

  // Bus answer, one cycle after request
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        if (sel_reg(wb_adr_i, REG_FLAGS_IDX)) wb_dat_o <= {26'h0, flags};
        // Trigger reads zero
        if (sel_reg(wb_adr_i, REG_STATUS_IDX)) wb_dat_o <= {30'h0, open_win, state != RCC_IDLE};
      end
    end
  end
endmodule : rcc_ctrl
`default_nettype wire

// ===== verif/rcc_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_ctrl_monitor
  import rcc_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Bus
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  // Sources and fuses
  input  wire rcc_req_s    req,
  input  wire logic        pin_reset_enable,
  input  wire logic [1:0]  checksum_source_field,
  // Domain resets
  input  wire rcc_dom_s    dom
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_hold_active: assert property (
    (req.poweron || req.brownout || (req.pin_low && pin_reset_enable))
    |-> ##[1:2] dom.volatile_domain) else $error("request not held");
  a_por_debug: assert property (
    req.poweron |-> ##[1:2] dom.debug_domain) else $error("debug domain missed");
  a_wdt_keeps_debug: assert property (
    (req.watchdog && !dom.debug_domain && !req.poweron && $stable(req.hv_edge))
    |=> !dom.debug_domain) else $error("debug domain disturbed");
  a_hv_full: assert property (
    $changed(req.hv_edge) |-> ##[1:2] (dom.fuse_reload && dom.debug_domain))
    else $error("hv edge without full reset");
  a_pc_with_logic: assert property (
    (dom.volatile_domain || dom.fuse_reload) |-> (dom.pc_clear && dom.volatile_domain))
    else $error("pc not cleared");
  a_init_min: assert property (
    ($fell(req.pin_low) && pin_reset_enable) |=> dom.volatile_domain [*8])
    else $error("init too short");
  a_scan_extend: assert property (
    ($fell(req.poweron) && checksum_source_field != 2'h3) |-> ##200 dom.volatile_domain)
    else $error("scan not added");
  a_trig_zero: assert property (
    (wb_ack_o && !wb_we_i && wb_adr_i == 4'h4) |-> wb_dat_o == 32'h0)
    else $error("trigger reads nonzero");
  a_flag_width: assert property (
    (wb_ack_o && !wb_we_i && wb_adr_i == 4'h0) |-> wb_dat_o[31:6] == 26'h0)
    else $error("flag upper bits set");
endmodule : rcc_ctrl_monitor
bind rcc_ctrl rcc_ctrl_monitor u_rcc_ctrl_monitor (.core_clk, .nrst, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .req, .pin_reset_enable, .checksum_source_field, .dom);
`default_nettype wire

// ===== verif/rcc_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_src_model
  import rcc_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Bench commands
  input  wire logic [5:0] cmd,
  input  wire logic       step_en,
  // Toward the controller
  output rcc_req_s        req,
  output logic            instr_step
);
  // Source levels; hv edge only on command
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) req <= '0;
    else req <= rcc_req_s'(cmd);
  end
  // One pulse per executed instruction
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) instr_step <= 1'b0;
    else instr_step <= step_en && !instr_step;
  end
endmodule : rcc_src_model
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb
  import rcc_pkg::*;
;
  logic        core_clk, nrst, cyc, stb, we, step_en, ack, instr_step;
  logic [3:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [5:0]  cmd;
  rcc_req_s    req;
  rcc_dom_s    dom;
  int          failures = 0, checks = 0, cycles = 0, i;
  logic [5:0]  src_tab [6] = '{6'h04, 6'h08, 6'h02, 6'h10, 6'h20, 6'h01};
  logic [7:0]  exp_tab [6] = '{8'h08, 8'h0c, 8'h2c, 8'h02, 8'h01, 8'h21};

  rcc_ctrl u_rcc_ctrl (.core_clk, .nrst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .req, .pin_reset_enable(1'b1), .instr_step, .startup_delay_field(4'h1),
    .checksum_source_field(2'h0), .dom);
  rcc_src_model u_rcc_src_model (.core_clk, .nrst, .cmd, .step_en, .req, .instr_step);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      conclude();
    end
  end

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    n = 0;
    do begin @(posedge core_clk); n++; end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50) failures++;
    {cyc, stb, we} <= 3'b000;
  endtask : bus
  task automatic settle;
    int n;
    n = 0;
    do begin @(posedge core_clk); n++; end while (dom.volatile_domain !== 1'b0 && n < 3000);
    if (n >= 3000) failures++;
  endtask : settle
  task automatic conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  initial begin
    {nrst, cyc, stb, we, adr, wdat, cmd, step_en} = '0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    settle();
    bus(0, 4'h0, 0); `CHK("flags", 32'h01, q)
    bus(0, 4'h4, 0); `CHK("trig rd", 32'h0, q)
    bus(0, 4'h1, 0); `CHK("unmapped", 32'h0, q)
    bus(1, 4'h0, 0); bus(0, 4'h0, 0); `CHK("w0 keep", 32'h01, q)
    bus(1, 4'h0, 1); bus(0, 4'h0, 0); `CHK("w1 clear", 32'h0, q)
    $display("regs done");
    bus(1, 4'h4, 1); repeat (3) @(posedge core_clk);
    `CHK("no key", 1'b0, dom.volatile_domain)
    bus(1, 4'h8, IO_REGISTER_KEY_DEFAULT); bus(0, 4'hc, 0);
    `CHK("open", 32'h2, q & 32'h2)
    step_en <= 1'b1;
    repeat (10) @(posedge core_clk);
    step_en <= 1'b0;
    bus(1, 4'h4, 1); repeat (3) @(posedge core_clk);
    `CHK("late trig", 1'b0, dom.volatile_domain)
    $display("lock done");
    bus(1, 4'h8, IO_REGISTER_KEY_DEFAULT); bus(1, 4'h4, 1); @(posedge core_clk);
    `CHK("soft rst", 1'b1, dom.volatile_domain)
    `CHK("soft dbg", 1'b0, dom.debug_domain)
    `CHK("soft fuse", 1'b1, dom.fuse_reload)
    `CHK("soft pc", 1'b1, dom.pc_clear)
    bus(0, 4'hc, 0); `CHK("busy", 32'h1, q & 32'h1)
    settle(); bus(0, 4'h0, 0); `CHK("soft flag", 32'h10, q)
    bus(1, 4'h0, 32'h3f);
    $display("soft done");
    for (i = 0; i < 6; i++) begin
      @(posedge core_clk);
      cmd <= src_tab[i];
      repeat (4) @(posedge core_clk);
      `CHK("dbg dom", src_tab[i][5] | src_tab[i][0], dom.debug_domain)
      cmd <= src_tab[i] & 6'h01;
      settle(); bus(0, 4'h0, 0); `CHK("src flag", {24'h0, exp_tab[i]}, q)
    end
    fork
      bus(1, 4'h0, 32'h08);
      begin
        @(posedge core_clk);
        cmd <= 6'h05;
        @(posedge core_clk);
        cmd <= 6'h01;
      end
    join
    settle(); bus(0, 4'h0, 0); `CHK("set wins", 32'h29, q)
    $display("sources done");
    conclude();
  end
endmodule : tb
`default_nettype wire
